// >>> core/rpfc_defs.vh
// Function
// - bit 0 clear: a one written to fast-reset port bit 0 restarts the CPU.
// - bit 0 set: that write raises a management interrupt instead.
// - bit 1 set locks the CMOS password area; clearing it never unlocks it.
// - bit 3 clear resets the CPU only outside HOLD, set only inside HOLD.
// - bit 4 clear: link code 101 restarts the CPU, else it feeds the mouse flop.
// - bit 5 set lets the mouse flop pull the pointer pin open-collector.
// - bit 7 clear holds the peripheral core in reset while power-good is low.
// - control bit 7 is cleared by the battery reset and not by power-good.
// - the battery reset input is ignored while power-good is high.
// - power-good and battery reset both low always reset the core.
`ifndef RPFC_DEFS_VH
`define RPFC_DEFS_VH

`define RPFC_OFF_CTRL 8'h0c
`define RPFC_OFF_IRQ_STAT 8'h10
`define RPFC_OFF_IRQ_MASK 8'h14
`define RPFC_OFF_LIVE 8'h18

`define RPFC_CTRL_RESET 8'h00
`define RPFC_CTRL_WMASK 8'hbb
// synchroniser reset: hold and power-good low, battery reset idle high
`define RPFC_SYNC_RESET 3'h2

`define RPFC_B_MGMT_MODE 0
`define RPFC_B_PW_PROT 1
`define RPFC_B_HOLD_MODE 3
`define RPFC_B_CODE_DIS 4
`define RPFC_B_AUX_EN 5
`define RPFC_B_CORE_KEEP 7

`define RPFC_LINK_RESTART 3'h5

`define RPFC_EV_MGMT 0
`define RPFC_EV_RESTART 1
`define RPFC_EV_PG_FALL 2
`define RPFC_EV_BATT 3
`define RPFC_EV_W 4

`define RPFC_CLK_MHZ 10
`define RPFC_CPU_RST_NS 2000
`define RPFC_CPU_RST_CYC ((`RPFC_CPU_RST_NS * `RPFC_CLK_MHZ + 999) / 1000)
`define RPFC_CNT_W 8

`endif

// >>> core/rpfc_sync2.v
`timescale 1ns/1ps
module rpfc_sync2 #(
	parameter WIDTH = 3
) (
	input wire clk,
	input wire rst,
	input wire [WIDTH-1:0] async_in,
	input wire [WIDTH-1:0] reset_val,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;

	// first stage read by the second stage only
	always @(posedge clk) begin
		if (rst) begin
			meta_q <= reset_val;
			sync_out <= reset_val;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // rpfc_sync2

// >>> core/rpfc_restart_gen.v
`timescale 1ns/1ps
`include "rpfc_defs.vh"
module rpfc_restart_gen (
	input wire clk,
	input wire rst,
	input wire restart_req,
	input wire hold_mode,
	input wire hold_s,
	output reg cpu_reset_q,
	output reg busy_q
);
	localparam integer PULSE_I = `RPFC_CPU_RST_CYC;
	localparam [`RPFC_CNT_W-1:0] PULSE = PULSE_I[`RPFC_CNT_W-1:0];
	reg [`RPFC_CNT_W-1:0] cnt_q;
	wire hold_ok;

	// mode bit picks which hold state a reset may start in
	assign hold_ok = hold_mode ? hold_s : ~hold_s;

	// pulse only counts while the hold condition is met, so it never shortens
	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= {`RPFC_CNT_W{1'b0}};
			busy_q <= 1'b0;
			cpu_reset_q <= 1'b0;
		end else begin
			if (!busy_q) begin
				cpu_reset_q <= 1'b0;
				if (restart_req) begin
					busy_q <= 1'b1;
					cnt_q <= PULSE;
				end
			end else if (hold_ok) begin
				cpu_reset_q <= 1'b1;
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == {{(`RPFC_CNT_W-1){1'b0}}, 1'b1})
					busy_q <= 1'b0;
			end else begin
				cpu_reset_q <= 1'b0;
			end
		end
	end
endmodule // rpfc_restart_gen

// >>> core/rpfc_top.v
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "rpfc_defs.vh"
module rpfc_top (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire main_power_good,
	input wire battery_reset_in_n,
	input wire cpu_hold_ack,
	input wire fast_reset_wr,
	input wire [7:0] fast_reset_data,
	input wire link_code_valid,
	input wire [2:0] link_code,
	input wire mouse_irq_ack,
	output reg cpu_reset,
	output reg system_mgmt_interrupt,
	output reg cmos_pw_lock,
	output reg aux_pointer_irq_out,
	output reg aux_pointer_irq_oe,
	output reg periph_core_reset,
	output reg irq
);
	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	reg [`RPFC_EV_W-1:0] stat_q;
	reg [`RPFC_EV_W-1:0] stat_d;
	reg [`RPFC_EV_W-1:0] mask_q;
	reg protect_q;
	reg mouse_ff_q;
	reg pg_prev_q;
	reg batt_prev_q;
	reg [7:0] rd_mux;
	wire [2:0] pins_s;
	wire pg_s;
	wire batt_n_s;
	wire hold_s;
	wire battery_reset_alt;
	wire wr_ctrl;
	wire wr_stat;
	wire wr_mask;
	wire port_one;
	wire link_hit;
	wire mgmt_ev;
	wire restart_ev;
	wire restart_req;
	wire cpu_rst_w;
	wire rst_busy;
	wire [`RPFC_EV_W-1:0] ev_vec;

	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// power-good, battery reset and hold all come from pins
	rpfc_sync2 #(
		.WIDTH(3)
	) u_sync (
		.clk(ref_clk),
		.rst(rst),
		.async_in({cpu_hold_ack, battery_reset_in_n, main_power_good}),
		.reset_val(`RPFC_SYNC_RESET),
		.sync_out(pins_s)
	);

	assign pg_s = pins_s[0];
	assign batt_n_s = pins_s[1];
	assign hold_s = pins_s[2];

	// battery reset only counts once main power is gone
	assign battery_reset_alt = ~batt_n_s & ~pg_s;

	assign wr_ctrl = reg_wr & hit(reg_addr, `RPFC_OFF_CTRL);
	assign wr_stat = reg_wr & hit(reg_addr, `RPFC_OFF_IRQ_STAT);
	assign wr_mask = reg_wr & hit(reg_addr, `RPFC_OFF_IRQ_MASK);

	assign port_one = fast_reset_wr & fast_reset_data[0];
	assign link_hit = link_code_valid & (link_code == `RPFC_LINK_RESTART);

	// firmware mode turns the port restart into an interrupt
	assign mgmt_ev = port_one & ctrl_q[`RPFC_B_MGMT_MODE];

	assign restart_ev = (port_one & ~ctrl_q[`RPFC_B_MGMT_MODE])
		| (link_hit & ~ctrl_q[`RPFC_B_CODE_DIS]);

	// a request during a running pulse is absorbed by it
	assign restart_req = restart_ev & ~rst_busy;

	rpfc_restart_gen u_restart (
		.clk(ref_clk),
		.rst(rst),
		.restart_req(restart_req),
		.hold_mode(ctrl_q[`RPFC_B_HOLD_MODE]),
		.hold_s(hold_s),
		.cpu_reset_q(cpu_rst_w),
		.busy_q(rst_busy)
	);

	// control register: reserved bits never stored
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = reg_wdata & `RPFC_CTRL_WMASK;
	end

	// low bits follow power-good, bit 7 follows the battery reset
	always @(posedge ref_clk) begin
		if (rst) begin
			ctrl_q <= `RPFC_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
			if (!pg_s)
				ctrl_q[6:0] <= 7'h00;
			if (battery_reset_alt)
				ctrl_q[`RPFC_B_CORE_KEEP] <= 1'b0;
		end
	end

	// lock is sticky: clearing bit 1 never reopens the area
	always @(posedge ref_clk) begin
		if (rst) begin
			protect_q <= 1'b0;
		end else if (ctrl_q[`RPFC_B_PW_PROT]) begin
			protect_q <= 1'b1;
		end
	end

	// mouse flop takes code 101 only when it is not a restart
	always @(posedge ref_clk) begin
		if (rst) begin
			mouse_ff_q <= 1'b0;
		end else if (link_hit & ctrl_q[`RPFC_B_CODE_DIS]) begin
			mouse_ff_q <= 1'b1;
		end else if (mouse_irq_ack) begin
			mouse_ff_q <= 1'b0;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			pg_prev_q <= 1'b0;
			batt_prev_q <= 1'b0;
		end else begin
			pg_prev_q <= pg_s;
			batt_prev_q <= battery_reset_alt;
		end
	end

	assign ev_vec = {battery_reset_alt & ~batt_prev_q,
		pg_prev_q & ~pg_s,
		restart_req,
		mgmt_ev};

	// set wins over a write-one clear in the same cycle
	always @* begin
		stat_d = stat_q;
		if (wr_stat)
			stat_d = stat_q & ~reg_wdata[`RPFC_EV_W-1:0];
		stat_d = stat_d | ev_vec;
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			stat_q <= {`RPFC_EV_W{1'b0}};
			mask_q <= {`RPFC_EV_W{1'b0}};
		end else begin
			stat_q <= stat_d;
			if (wr_mask)
				mask_q <= reg_wdata[`RPFC_EV_W-1:0];
		end
	end

	always @* begin
		rd_mux = 8'h00;
		if (hit(reg_addr, `RPFC_OFF_CTRL))
			rd_mux = ctrl_q & `RPFC_CTRL_WMASK;
		else if (hit(reg_addr, `RPFC_OFF_IRQ_STAT))
			rd_mux = {4'h0, stat_q};
		else if (hit(reg_addr, `RPFC_OFF_IRQ_MASK))
			rd_mux = {4'h0, mask_q};
		else if (hit(reg_addr, `RPFC_OFF_LIVE))
			rd_mux = {1'b0, periph_core_reset, cpu_reset, mouse_ff_q,
				protect_q, hold_s, batt_n_s, pg_s};
	end

	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end

	// all pins registered; the pointer pin is only ever pulled low
	always @(posedge ref_clk) begin
		if (rst) begin
			cpu_reset <= 1'b0;
			system_mgmt_interrupt <= 1'b0;
			cmos_pw_lock <= 1'b0;
			aux_pointer_irq_out <= 1'b0;
			aux_pointer_irq_oe <= 1'b0;
			periph_core_reset <= 1'b1;
			irq <= 1'b0;
		end else begin
			cpu_reset <= cpu_rst_w;
			system_mgmt_interrupt <= mgmt_ev;
			cmos_pw_lock <= protect_q | ctrl_q[`RPFC_B_PW_PROT];
			aux_pointer_irq_out <= 1'b0;
			aux_pointer_irq_oe <= ctrl_q[`RPFC_B_AUX_EN] & mouse_ff_q;
			periph_core_reset <= (~pg_s & ~ctrl_q[`RPFC_B_CORE_KEEP])
				| battery_reset_alt;
			irq <= |(stat_d & mask_q);
		end
	end
endmodule // rpfc_top

// >>> sim/rpfc_monitor.sv
`timescale 1ns/1ps
module rpfc_monitor (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire main_power_good,
	input wire battery_reset_in_n,
	input wire fast_reset_wr,
	input wire [7:0] fast_reset_data,
	input wire cpu_reset,
	input wire system_mgmt_interrupt,
	input wire cmos_pw_lock,
	input wire aux_pointer_irq_out,
	input wire periph_core_reset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	reg [4:0] hi_q;
	reg req_q;
	// run length of cpu reset, drops restart the count
	always @(posedge ref_clk) begin
		hi_q <= (rst || !cpu_reset) ? 5'h00 : hi_q + 5'h01;
		req_q <= !rst && fast_reset_wr && fast_reset_data[0];
	end
	sequence s_good;
		main_power_good [*6];
	endsequence
	sequence s_dead;
		(!main_power_good && !battery_reset_in_n) [*6];
	endsequence
	a_mgmt_cause: assert property (system_mgmt_interrupt |-> req_q)
		else $error("management interrupt without port write");
	a_reset_width: assert property (cpu_reset |-> hi_q < 5'h14)
		else $error("cpu reset too long");
	a_lock_sticky: assert property (cmos_pw_lock |=> cmos_pw_lock)
		else $error("password lock released");
	a_pin_low: assert property (aux_pointer_irq_out == 1'h0)
		else $error("pointer pin driven high");
	a_pg_good: assert property (s_good |-> !periph_core_reset)
		else $error("core reset with power good");
	a_both_low: assert property (s_dead |-> periph_core_reset)
		else $error("core not reset");
	a_rsvd_zero: assert property (reg_rd && reg_addr == 8'h0c |=>
		(reg_rdata & 8'h44) == 8'h00) else $error("reserved bits set");
	a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside slot");
endmodule // rpfc_monitor
bind rpfc_top rpfc_monitor u_mon (.*);

// >>> sim/rpfc_cpu_model.sv
`timescale 1ns/1ps
module rpfc_cpu_model (
	input wire ref_clk,
	input wire hold_req,
	output wire cpu_hold_ack
);
	// slow grant: ack lags the request by three clocks
	reg [2:0] lag_q = 3'h0;
	always @(posedge ref_clk) lag_q <= {lag_q[1:0], hold_req};
	assign cpu_hold_ack = lag_q[2];
endmodule // rpfc_cpu_model

// >>> sim/rpfc_tb.sv
`timescale 1ns/1ps
`include "rpfc_defs.vh"
module testbench;
	reg ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	reg pg = 1'h1, batt_n = 1'h1, hold_req = 1'h0, fr_wr = 1'h0;
	reg lc_v = 1'h0, m_ack = 1'h0, rd_q = 1'h0;
	reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fr_d = 8'h00, v;
	reg [2:0] lc = 3'h0;
	reg [7:0] exp_q[$];
	wire [7:0] reg_rdata;
	wire hold, cpu_reset, mgmt, lock, pin, oe, core_rst, irq;
	integer failures = 0, n_compared = 0, seed = 31644, i, n;
	always #50 ref_clk = ~ref_clk;
	rpfc_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .main_power_good(pg),
		.battery_reset_in_n(batt_n), .cpu_hold_ack(hold),
		.fast_reset_wr(fr_wr), .fast_reset_data(fr_d),
		.link_code_valid(lc_v), .link_code(lc), .mouse_irq_ack(m_ack),
		.cpu_reset(cpu_reset), .system_mgmt_interrupt(mgmt),
		.cmos_pw_lock(lock), .aux_pointer_irq_out(pin),
		.aux_pointer_irq_oe(oe), .periph_core_reset(core_rst),
		.irq(irq));
	rpfc_cpu_model cpu (.ref_clk(ref_clk), .hold_req(hold_req),
		.cpu_hold_ack(hold));
	task chk(input [7:0] got, input [7:0] e);
		n_compared = n_compared + 1;
		if (got !== e) begin
			failures = failures + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'h0;
	endtask
	// k=1 sends link code 101, else a one to the fast-reset port
	task req(input k);
		@(posedge ref_clk);
		lc_v <= k;
		lc <= 3'h5;
		fr_wr <= !k;
		fr_d <= 8'h01;
		@(posedge ref_clk);
		fr_wr <= 1'h0;
		lc_v <= 1'h0;
		#1;
	endtask
	// bounded: a reset that never comes shows as a length of zero
	task rst_len;
		n = 0;
		for (i = 0; i < 12 && !cpu_reset; i++) cyc(1);
		while (cpu_reset && n < 40) begin
			cyc(1);
			n++;
		end
	endtask
	// read data belong to the strobe one edge earlier
	always @(posedge ref_clk) begin
		if (rd_q) chk(reg_rdata, exp_q.pop_front());
		rd_q <= reg_rd;
	end
	task results;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		cyc(4);
		rd(`RPFC_OFF_CTRL, 8'h00);
		rd(8'h04, 8'h00);
		for (n = 0; n < 4; n++) begin
			v = 8'($random(seed));
			wr(`RPFC_OFF_CTRL, v);
			rd(`RPFC_OFF_CTRL, v & 8'hbb);
		end
		wr(`RPFC_OFF_CTRL, 8'h02);
		wr(`RPFC_OFF_CTRL, 8'h00);
		cyc(1);
		chk({7'h00, lock}, 8'h01);
		$display("register test done");
		req(1'h0);
		chk({7'h00, mgmt}, 8'h00);
		rst_len;
		chk(n[7:0], 8'h14);
		wr(`RPFC_OFF_IRQ_MASK, 8'h01);
		wr(`RPFC_OFF_CTRL, 8'h01);
		req(1'h0);
		chk({6'h00, cpu_reset, mgmt}, 8'h01);
		cyc(3);
		chk({6'h00, cpu_reset, irq}, 8'h01);
		wr(`RPFC_OFF_IRQ_MASK, 8'h00);
		cyc(1);
		chk({7'h00, irq}, 8'h00);
		wr(`RPFC_OFF_IRQ_MASK, 8'h01);
		wr(`RPFC_OFF_IRQ_STAT, 8'h01);
		cyc(1);
		chk({7'h00, irq}, 8'h00);
		rd(`RPFC_OFF_IRQ_STAT, 8'h02);
		rd(`RPFC_OFF_IRQ_MASK, 8'h01);
		$display("port restart test done");
		wr(`RPFC_OFF_CTRL, 8'h08);
		req(1'h0);
		cyc(6);
		chk({7'h00, cpu_reset}, 8'h00);
		hold_req <= 1'h1;
		rst_len;
		chk(n[7:0], 8'h14);
		hold_req <= 1'h0;
		wr(`RPFC_OFF_CTRL, 8'h00);
		req(1'h1);
		rst_len;
		chk(n[7:0], 8'h14);
		wr(`RPFC_OFF_CTRL, 8'h30);
		req(1'h1);
		cyc(3);
		chk({6'h00, oe, cpu_reset}, 8'h02);
		m_ack <= 1'h1;
		@(posedge ref_clk);
		m_ack <= 1'h0;
		wr(`RPFC_OFF_CTRL, 8'h10);
		req(1'h1);
		cyc(3);
		chk({6'h00, oe, cpu_reset}, 8'h00);
		$display("link code test done");
		wr(`RPFC_OFF_CTRL, 8'h80);
		pg <= 1'h0;
		cyc(6);
		chk({7'h00, core_rst}, 8'h00);
		pg <= 1'h1;
		batt_n <= 1'h0;
		cyc(6);
		rd(`RPFC_OFF_CTRL, 8'h80);
		pg <= 1'h0;
		cyc(6);
		chk({7'h00, core_rst}, 8'h01);
		pg <= 1'h1;
		batt_n <= 1'h1;
		cyc(4);
		rd(`RPFC_OFF_CTRL, 8'h00);
		pg <= 1'h0;
		cyc(6);
		chk({7'h00, core_rst}, 8'h01);
		pg <= 1'h1;
		cyc(4);
		$display("power test done");
		results;
	end
endmodule // testbench
